/* core/hbp_device.sv */
// Device end of the host bus port: bridges link transfers to the system bus.
// Assumes the system bus answers reads in the same cycle as the request.
module hbp_device
  import hbp_pkg::*;
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  // Link
  hbp_if.dev LINK,
  // Static configuration
  input wire logic I_WIDE,
  input wire logic I_SYSCLK_FROM_LINK,
  output logic O_SYNC_MODE,
  // System bus
  output logic O_SB_REQ,
  output logic O_SB_WE,
  output logic [ADDR_W-1:0] O_SB_ADDR,
  output logic [DATA_W-1:0] O_SB_WDATA,
  output logic [1:0] O_SB_BE,
  input wire logic [DATA_W-1:0] I_SB_RDATA,
  input wire logic I_SB_ERR,
  // Interrupt service
  input wire logic I_IRQ_CLR,
  output logic O_IRQ_PEND
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int SW = 7 + 2 + ADDR_W + DATA_W + PAR_W;

  logic [SW-1:0] raw;
  logic [SW-1:0] syn;
  logic clk_s;
  logic start_n_s;
  logic sel_l_s;
  logic sel_h_s;
  logic rnw_s;
  logic burst_n_s;
  logic bdip_n_s;
  logic [1:0] size_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic [PAR_W-1:0] par_s;

  assign raw = {LINK.host_bus_clock, LINK.start_n, LINK.select_active_low,
                LINK.select_active_high, LINK.read_not_write, LINK.burst_active_n,
                LINK.burst_continue_n, LINK.transfer_size, LINK.addr,
                LINK.data_lanes, LINK.byte_parity_lanes};

  hbp_sync2 #(.W(SW)) u_sync (
    .i_clk(I_REF_CLK),
    .i_rstn(I_RSTN),
    .i_d(raw),
    .o_q(syn)
  );

  assign {clk_s, start_n_s, sel_l_s, sel_h_s, rnw_s, burst_n_s, bdip_n_s, size_s,
          addr_s, data_s, par_s} = syn;

  // ****************************************
  // Link edge and decode
  // ****************************************
  logic clk_prev_q;
  logic rise;
  logic sel_on;
  logic more;

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RSTN)
      clk_prev_q <= 1'h0;
    else
      clk_prev_q <= clk_s;
  end

  assign rise = clk_s & ~clk_prev_q;
  assign sel_on = ~sel_l_s & sel_h_s;

  // ****************************************
  // Sync mode strap
  // ****************************************
  // Strap is caught once after release so reset stays constant-only
  logic strap_done_q;
  logic sync_q;

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RSTN)
    begin
      strap_done_q <= 1'h0;
      sync_q <= 1'h0;
    end
    else if (!strap_done_q)
    begin
      strap_done_q <= 1'h1;
      sync_q <= I_SYSCLK_FROM_LINK;
    end
  end

  assign O_SYNC_MODE = sync_q;

  // ****************************************
  // Transfer sequencer
  // ****************************************
  dev_state_e state_q;
  logic rnw_q;
  logic burst_q;
  logic [BEAT_W-1:0] beats_q;
  logic [ADDR_W-1:0] addr_q;
  logic [1:0] be_q;
  logic ack_q;
  logic rd_drive_q;
  logic req_q;
  logic [DATA_W-1:0] wdata_q;
  logic [PAR_W-1:0] wpar_q;

  // Burst runs while the continue line is low; single counts its beats
  assign more = burst_q ? ~bdip_n_s : (beats_q > BEAT_ONE);

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RSTN)
    begin
      state_q <= D_IDLE;
      rnw_q <= 1'h0;
      burst_q <= 1'h0;
      beats_q <= '0;
      addr_q <= '0;
      be_q <= '0;
      ack_q <= 1'h0;
      rd_drive_q <= 1'h0;
    end
    else if (rise)
    begin
      unique case (state_q)
        D_IDLE:
        begin
          rd_drive_q <= 1'h0;
          if (!start_n_s)
          begin
            rnw_q <= rnw_s;
            burst_q <= ~burst_n_s;
            beats_q <= beats_for(size_s, I_WIDE);
            addr_q <= addr_s;
            be_q <= (size_s == SIZE_BYTE || !I_WIDE) ? BE_LOW : BE_BOTH;
            // Selects already valid in address phase skip the wait cycle, on reads only in sync mode
            if (sel_on && (sync_q || !rnw_s))
              state_q <= D_BEAT;
            else
              state_q <= D_WAIT;
          end
        end
        D_WAIT:
        begin
          if (sel_on)
            state_q <= D_BEAT;
        end
        D_BEAT:
        begin
          if (sel_on)
          begin
            ack_q <= 1'h1;
            rd_drive_q <= rnw_q;
            state_q <= D_ACK;
          end
        end
        D_ACK:
        begin
          ack_q <= 1'h0;
          if (more)
          begin
            beats_q <= beats_q - BEAT_ONE;
            addr_q <= addr_q + (I_WIDE ? ADDR_STEP_WIDE : ADDR_STEP_NARROW);
            state_q <= D_BEAT;
          end
          else
          begin
            state_q <= D_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // System bus access
  // ****************************************
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RSTN)
    begin
      req_q <= 1'h0;
      wdata_q <= '0;
      wpar_q <= '0;
    end
    else
    begin
      req_q <= rise && state_q == D_BEAT && sel_on;
      if (rise && state_q == D_BEAT && sel_on && !rnw_q)
      begin
        wdata_q <= data_s;
        wpar_q <= par_s;
      end
    end
  end

  assign O_SB_REQ = req_q;
  assign O_SB_WE = ~rnw_q;
  assign O_SB_ADDR = addr_q;
  assign O_SB_WDATA = wdata_q;
  assign O_SB_BE = be_q;

  // ****************************************
  // Read data and parity out
  // ****************************************
  logic [DATA_W-1:0] dout_q;
  logic [PAR_W-1:0] pout_q;

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RSTN)
    begin
      dout_q <= '0;
      pout_q <= '0;
    end
    else if (req_q && rnw_q)
    begin
      dout_q <= I_SB_RDATA;
      pout_q <= lane_par(I_SB_RDATA);
    end
  end

  // Released as soon as a synchronised select drops, so the master never meets us
  assign LINK.dev_data = dout_q;
  assign LINK.dev_par = pout_q;
  assign LINK.dev_data_oe = rd_drive_q & sel_on;
  assign LINK.dev_par_oe = rd_drive_q & sel_on;
  assign LINK.ack_n = ~ack_q;

  // ****************************************
  // Error flag and interrupt
  // ****************************************
  logic [PAR_W-1:0] par_mask;
  logic par_err;
  logic irq_q;

  assign par_mask = {1'h0, be_q[1], be_q[0]};
  assign par_err = req_q & ~rnw_q & |((lane_par(wdata_q) ^ wpar_q) & par_mask);

  // A new error in the clearing cycle keeps the flag set
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RSTN)
      irq_q <= 1'h0;
    else if (par_err || I_SB_ERR)
      irq_q <= 1'h1;
    else if (I_IRQ_CLR)
      irq_q <= 1'h0;
  end

  assign LINK.host_interrupt_n = ~irq_q;
  assign O_IRQ_PEND = irq_q;

endmodule

/* core/hbp_host.sv */
// Bus master end of the host bus port: makes the link clock and runs transfers.
// Assumes the user holds request fields steady while O_BUSY is high.
module hbp_host
  import hbp_pkg::*;
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  // Link
  hbp_if.host LINK,
  // Configuration
  input wire logic I_WIDE,
  input wire logic I_LATE_SELECT,
  // Request
  input wire logic I_START,
  input wire logic I_RNW,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [1:0] I_SIZE,
  input wire logic [BEAT_W-1:0] I_BURST_BEATS,
  input wire logic I_ABORT,
  // Beat data
  input wire logic [DATA_W-1:0] I_WDATA,
  output logic O_WDATA_TAKE,
  output logic [DATA_W-1:0] O_RDATA,
  output logic O_RVALID,
  // Status
  output logic O_BUSY,
  output logic O_IRQ
);

  // ****************************************
  // Link clock divider
  // ****************************************
  logic [2:0] div_q;
  logic clk_q;
  logic rise;
  logic fall;

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RSTN)
    begin
      // Parked on the last count so the first high time after reset is full
      div_q <= DIV_LAST;
      clk_q <= 1'h0;
    end
    else
    begin
      div_q <= (div_q == DIV_LAST) ? 3'h0 : div_q + 3'h1;
      clk_q <= (div_q == DIV_LAST) || (div_q < DIV_FALL);
    end
  end

  // Sample just before the rising edge, launch at the falling edge
  assign rise = div_q == DIV_LAST;
  assign fall = div_q == DIV_FALL;
  assign LINK.host_bus_clock = clk_q;

  // ****************************************
  // Device output synchronisers
  // ****************************************
  logic [DATA_W+1:0] syn;
  logic ack_n_s;
  logic irq_n_s;
  logic [DATA_W-1:0] data_s;

  hbp_sync2 #(.W(DATA_W + 2)) u_sync (
    .i_clk(I_REF_CLK),
    .i_rstn(I_RSTN),
    .i_d({LINK.ack_n, LINK.host_interrupt_n, LINK.data_lanes}),
    .o_q(syn)
  );

  assign {ack_n_s, irq_n_s, data_s} = syn;

  // ****************************************
  // Transfer sequencer
  // ****************************************
  host_state_e state_q;
  logic req_q;
  logic abort_q;
  logic got_q;
  logic burst_q;
  logic [BEAT_W-1:0] left_q;
  logic start_n_q;
  logic sel_q;
  logic bdip_n_q;
  logic wr_oe_q;
  logic [DATA_W-1:0] wdata_q;
  logic last;
  logic next_beat;

  assign last = (left_q == BEAT_ONE) || (burst_q && bdip_n_q);
  assign next_beat = fall && state_q == H_DATA && got_q && !last;
  assign O_WDATA_TAKE = fall && !I_RNW && ((state_q == H_IDLE && req_q) || next_beat);

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RSTN)
    begin
      state_q <= H_IDLE;
      req_q <= 1'h0;
      abort_q <= 1'h0;
      got_q <= 1'h0;
      burst_q <= 1'h0;
      left_q <= '0;
      start_n_q <= 1'h1;
      sel_q <= 1'h0;
      bdip_n_q <= 1'h1;
      wr_oe_q <= 1'h0;
      wdata_q <= '0;
      O_RDATA <= '0;
      O_RVALID <= 1'h0;
    end
    else
    begin
      O_RVALID <= 1'h0;
      if (I_START && state_q == H_IDLE)
        req_q <= 1'h1;
      if (I_ABORT && state_q != H_IDLE)
        abort_q <= 1'h1;
      if (O_WDATA_TAKE)
        wdata_q <= I_WDATA;
      if (rise && state_q == H_DATA && !ack_n_s)
      begin
        got_q <= 1'h1;
        O_RDATA <= data_s;
        O_RVALID <= I_RNW;
      end
      if (fall)
      begin
        unique case (state_q)
          H_IDLE:
          begin
            if (req_q)
            begin
              req_q <= 1'h0;
              abort_q <= 1'h0;
              burst_q <= I_BURST_BEATS != '0;
              left_q <= (I_BURST_BEATS != '0) ? I_BURST_BEATS : beats_for(I_SIZE, I_WIDE);
              bdip_n_q <= !(I_BURST_BEATS > BEAT_ONE);
              start_n_q <= 1'h0;
              sel_q <= !I_LATE_SELECT;
              wr_oe_q <= !I_RNW;
              state_q <= H_ADDR;
            end
          end
          H_ADDR:
          begin
            start_n_q <= 1'h1;
            sel_q <= 1'h1;
            state_q <= H_DATA;
          end
          H_DATA:
          begin
            if (got_q)
            begin
              got_q <= 1'h0;
              if (last)
              begin
                sel_q <= 1'h0;
                wr_oe_q <= 1'h0;
                bdip_n_q <= 1'h1;
                state_q <= H_IDLE;
              end
              else
              begin
                left_q <= left_q - BEAT_ONE;
                bdip_n_q <= !(burst_q && left_q > 4'h2 && !abort_q);
              end
            end
          end
          default:
            state_q <= H_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Link drive
  // ****************************************
  assign LINK.start_n = start_n_q;
  assign LINK.addr = I_ADDR;
  assign LINK.select_active_low = ~sel_q;
  assign LINK.select_active_high = sel_q;
  assign LINK.transfer_size = I_SIZE;
  assign LINK.read_not_write = I_RNW;
  assign LINK.burst_active_n = ~burst_q;
  assign LINK.burst_continue_n = bdip_n_q;
  assign LINK.host_data = wdata_q;
  assign LINK.host_data_oe = wr_oe_q;
  assign LINK.host_par = lane_par(wdata_q);
  assign LINK.host_par_oe = wr_oe_q;

  assign O_BUSY = req_q || state_q != H_IDLE;

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RSTN)
      O_IRQ <= 1'h0;
    else
      O_IRQ <= ~irq_n_s;
  end

endmodule

/* core/hbp_sync2.sv */
// Two-stage synchroniser for a bundle of slow-changing levels.
// Assumes each bit is a level held for several clock periods.
module hbp_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Levels
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      meta_q <= '0;
      o_q <= '0;
    end
    else
    begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule

/* include/hbp_if.sv */
// Link between the host bus port device end and its bus master.
// Resolves the shared data and parity lanes; undriven lanes read high.
interface hbp_if;
  import hbp_pkg::*;

  logic host_bus_clock;
  logic start_n;
  logic [ADDR_W-1:0] addr;
  logic select_active_low;
  logic select_active_high;
  logic [1:0] transfer_size;
  logic read_not_write;
  logic burst_active_n;
  logic burst_continue_n;
  logic ack_n;
  logic host_interrupt_n;
  logic [DATA_W-1:0] dev_data;
  logic dev_data_oe;
  logic [PAR_W-1:0] dev_par;
  logic dev_par_oe;
  logic [DATA_W-1:0] host_data;
  logic host_data_oe;
  logic [PAR_W-1:0] host_par;
  logic host_par_oe;
  logic [DATA_W-1:0] data_lanes;
  logic [PAR_W-1:0] byte_parity_lanes;

  // Pull-ups hold the lanes high when nobody drives
  assign data_lanes = dev_data_oe ? dev_data : (host_data_oe ? host_data : DATA_PULLUP);
  assign byte_parity_lanes = dev_par_oe ? dev_par : (host_par_oe ? host_par : PAR_PULLUP);

  modport dev (
    input host_bus_clock, start_n, addr, select_active_low, select_active_high,
    input transfer_size, read_not_write, burst_active_n, burst_continue_n,
    input data_lanes, byte_parity_lanes,
    output ack_n, host_interrupt_n, dev_data, dev_data_oe, dev_par, dev_par_oe
  );

  modport host (
    output host_bus_clock, start_n, addr, select_active_low, select_active_high,
    output transfer_size, read_not_write, burst_active_n, burst_continue_n,
    output host_data, host_data_oe, host_par, host_par_oe,
    input ack_n, host_interrupt_n, data_lanes, byte_parity_lanes
  );
endinterface

/* include/hbp_pkg.sv */
// Constants, types and helpers shared by both ends of the host bus port.
// Assumes a 10 MHz reference clock at both ends and a link clock of 800 ns.
//
// Operation
// - Data lanes selectable 8 or 16 bits
// - Master drives writes, device drives reads
// - Low eight lines form first byte lane
// - One even parity bit per byte lane
// - Interrupt low on bus or parity error
// - Master holds both selects through data phase
// - Early selects save one cycle on reads; the device saves it in sync mode only
// - Link clock as system clock: sync mode
// - Sampled and launched on link rising edge; the host launches at the falling edge
// - Size 01 byte, 10 half, 00 word
// - Direction high read, low write
// - Burst line low for burst, high single
// - Continue line low requests next beat
// - Continue released early aborts the burst
package hbp_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int PAR_W = 3;
  localparam int ADDR_W = 8;
  localparam int BEAT_W = 4;

  // ****************************************
  // Encodings and idle levels
  // ****************************************
  localparam logic [1:0] SIZE_WORD = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_HALF = 2'h2;
  localparam logic [1:0] BE_LOW = 2'h1;
  localparam logic [1:0] BE_BOTH = 2'h3;
  localparam logic [DATA_W-1:0] DATA_PULLUP = 16'hFFFF;
  localparam logic [PAR_W-1:0] PAR_PULLUP = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_STEP_NARROW = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_STEP_WIDE = 8'h02;
  localparam logic [BEAT_W-1:0] BEAT_ONE = 4'h1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  localparam int LINK_DIV = LINK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [2:0] DIV_LAST = 3'(LINK_DIV - 1);
  localparam logic [2:0] DIV_HALF = 3'(LINK_DIV / 2);
  localparam logic [2:0] DIV_FALL = 3'(LINK_DIV / 2 - 1);

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [1:0] {D_IDLE = 2'h0, D_WAIT = 2'h1, D_BEAT = 2'h2, D_ACK = 2'h3} dev_state_e;
  typedef enum logic [1:0] {H_IDLE = 2'h0, H_ADDR = 2'h1, H_DATA = 2'h2} host_state_e;

  // Beats per single transfer; reserved size code moves one beat
  function automatic logic [BEAT_W-1:0] beats_for(input logic [1:0] size, input logic wide);
    logic [BEAT_W-1:0] n;
    n = BEAT_ONE;
    if (size == SIZE_HALF)
      n = wide ? 4'h1 : 4'h2;
    else if (size == SIZE_WORD)
      n = wide ? 4'h2 : 4'h4;
    return n;
  endfunction

  // Even parity; the top lane has no data lines so its bit stays low
  function automatic logic [PAR_W-1:0] lane_par(input logic [DATA_W-1:0] d);
    return {1'h0, ^d[2*LANE_W-1:LANE_W], ^d[LANE_W-1:0]};
  endfunction

endpackage

/* tb/hbp_props.sv */
// Link checker for the host bus port, watching the shared interface signals.
// Assumes one reference clock domain for both ends and the link.
module hbp_props
  import hbp_pkg::*;
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  // Link
  input wire logic host_bus_clock,
  input wire logic start_n,
  input wire logic select_active_low,
  input wire logic select_active_high,
  input wire logic read_not_write,
  input wire logic burst_active_n,
  input wire logic burst_continue_n,
  input wire logic ack_n,
  input wire logic [DATA_W-1:0] dev_data,
  input wire logic [PAR_W-1:0] dev_par,
  input wire logic dev_data_oe,
  input wire logic dev_par_oe,
  input wire logic host_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Shared timing
  // ****************************************
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RSTN);

  // Strobe low for exactly one link period of eight reference clocks
  sequence low_one_link(logic s);
    (!s)[*8] ##1 s;
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  ack_one_link_a: assert property ($fell(ack_n) |-> low_one_link(ack_n))
    else $error("ack not low for one link period");
  start_one_link_a: assert property ($fell(start_n) |-> low_one_link(start_n))
    else $error("start marker not low for one link period");
  clock_shape_a: assert property ($rose(host_bus_clock) |-> (host_bus_clock)[*4] ##1 !host_bus_clock)
    else $error("link clock high time wrong");
  launch_low_a: assert property ($changed(start_n) |-> !host_bus_clock)
    else $error("start marker moved while link clock high");
  select_hold_a: assert property (!ack_n |-> !select_active_low && select_active_high)
    else $error("selects dropped during data phase");
  no_contention_a: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data lanes");
  host_write_a: assert property (host_data_oe |-> !read_not_write)
    else $error("host drives lanes on a read");
  lane_parity_a: assert property (dev_par_oe && $stable(dev_data) |->
    dev_par == {1'b0, ^dev_data[15:8], ^dev_data[7:0]})
    else $error("device parity wrong");
  burst_cont_a: assert property (!burst_continue_n |-> !burst_active_n)
    else $error("continue asserted outside a burst");
  start_ack_a: assert property ($fell(start_n) |-> ##[1:40] $fell(ack_n))
    else $error("no beat acknowledge after start");
endmodule

/* tb/testbench.sv */
// Bench joining both ends of the host bus port over one interface.
// Assumes a same-cycle system bus memory model kept in this module.
module testbench
  import hbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic wide = 1'b1;
  logic strap = 1'b1;
  logic late = 1'b0;
  logic start = 1'b0;
  logic rnw = 1'b0;
  logic abort = 1'b0;
  logic sb_err = 1'b0;
  logic irq_clr = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [1:0] size = 2'h0;
  logic [BEAT_W-1:0] nbeats = 4'h0;
  logic [DATA_W-1:0] wdata, rdata, sb_wdata, sb_rdata;
  logic [ADDR_W-1:0] sb_addr;
  logic [1:0] sb_be;
  logic sync_mode, sb_req, sb_we, irq_pend, take, rvalid, busy, host_irq, sn_q;
  logic [7:0] mem [256];
  logic [DATA_W-1:0] wd [8] = '{default: 16'h0000};
  logic [DATA_W-1:0] rq [$];
  logic [ADDR_W-1:0] aq [$];
  int widx, cyc, t_s, t_r, lat_e, lat_l, miscompares, samples_checked;

  // ****************************************
  // Design and checker
  // ****************************************
  hbp_if hif ();
  hbp_device hbp_device_inst (.I_REF_CLK(ref_clk), .I_RSTN(rstn), .LINK(hif.dev),
    .I_WIDE(wide), .I_SYSCLK_FROM_LINK(strap), .O_SYNC_MODE(sync_mode), .O_SB_REQ(sb_req),
    .O_SB_WE(sb_we), .O_SB_ADDR(sb_addr), .O_SB_WDATA(sb_wdata), .O_SB_BE(sb_be),
    .I_SB_RDATA(sb_rdata), .I_SB_ERR(sb_err), .I_IRQ_CLR(irq_clr), .O_IRQ_PEND(irq_pend));
  hbp_host hbp_host_inst (.I_REF_CLK(ref_clk), .I_RSTN(rstn), .LINK(hif.host),
    .I_WIDE(wide), .I_LATE_SELECT(late), .I_START(start), .I_RNW(rnw), .I_ADDR(addr),
    .I_SIZE(size), .I_BURST_BEATS(nbeats), .I_ABORT(abort), .I_WDATA(wdata),
    .O_WDATA_TAKE(take), .O_RDATA(rdata), .O_RVALID(rvalid), .O_BUSY(busy), .O_IRQ(host_irq));
  hbp_props hbp_props_inst (.I_REF_CLK(ref_clk), .I_RSTN(rstn),
    .host_bus_clock(hif.host_bus_clock), .start_n(hif.start_n),
    .select_active_low(hif.select_active_low), .select_active_high(hif.select_active_high),
    .read_not_write(hif.read_not_write), .burst_active_n(hif.burst_active_n),
    .burst_continue_n(hif.burst_continue_n), .ack_n(hif.ack_n), .dev_data(hif.dev_data),
    .dev_par(hif.dev_par), .dev_data_oe(hif.dev_data_oe), .dev_par_oe(hif.dev_par_oe),
    .host_data_oe(hif.host_data_oe));

  // ****************************************
  // Clock, memory model and monitors
  // ****************************************
  initial forever #50 ref_clk = ~ref_clk;
  assign wdata = wd[widx[2:0]];
  assign sb_rdata = {mem[8'(sb_addr + 8'h01)], mem[sb_addr]};

  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    sn_q <= hif.start_n;
    // Per-transfer bookkeeping restarts on the start pulse, one writer each
    if (start)
    begin
      rq.delete();
      aq.delete();
    end
    if (sn_q && !hif.start_n) t_s <= cyc;
    if (rvalid && rq.size() == 0) t_r <= cyc;
    if (rvalid) rq.push_back(rdata);
    if (start)
      widx <= 0;
    else if (take)
      widx <= widx + 1;
    if (sb_req) aq.push_back(sb_addr);
    if (sb_req && sb_we && sb_be[0]) mem[sb_addr] <= sb_wdata[7:0];
    if (sb_req && sb_we && sb_be[1]) mem[8'(sb_addr + 8'h01)] <= sb_wdata[15:8];
    // Hang guard, far above the length of the sequence below
    if (cyc == 30000)
    begin
      miscompares++;
      summarize();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic summarize();
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic do_reset(input logic w, input logic s);
    @(negedge ref_clk);
    rstn = 1'b0;
    wide = w;
    strap = s;
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    // Strap and synchronisers settle before the first start
    repeat (16) @(negedge ref_clk);
  endtask

  task automatic xfer(input logic r, input logic [ADDR_W-1:0] a, input logic [1:0] s,
                      input logic [BEAT_W-1:0] nb, input logic ab);
    int n;
    logic sent;
    @(negedge ref_clk);
    sent = 1'b0;
    rnw = r;
    addr = a;
    size = s;
    nbeats = nb;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    for (n = 0; n < 400 && busy !== 1'b0; n++)
    begin
      @(negedge ref_clk);
      // One-cycle abort once the second beat is on offer
      abort = ab && widx == 1 && !sent;
      sent = sent | abort;
    end
    abort = 1'b0;
    chk({15'h0000, busy}, 16'h0000);
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    for (int i = 0; i < 256; i++) mem[i] = ~8'(i);
    do_reset(1'b1, 1'b1);
    chk({15'h0000, sync_mode}, 16'h0001);
    wd[0] = 16'h1234;
    wd[1] = 16'h5678;
    xfer(1'b0, 8'h20, SIZE_WORD, 4'h0, 1'b0);
    chk({mem[8'h21], mem[8'h20]}, 16'h1234);
    chk({mem[8'h23], mem[8'h22]}, 16'h5678);
    xfer(1'b1, 8'h20, SIZE_WORD, 4'h0, 1'b0);
    chk(rq[0], 16'h1234);
    chk(rq[1], 16'h5678);
    lat_e = t_r - t_s;
    wd[0] = 16'h5AA5;
    xfer(1'b0, 8'h30, SIZE_BYTE, 4'h0, 1'b0);
    chk({mem[8'h31], mem[8'h30]}, {~8'h31, 8'hA5});
    late = 1'b1;
    xfer(1'b1, 8'h30, SIZE_HALF, 4'h0, 1'b0);
    late = 1'b0;
    chk(rq[0], {~8'h31, 8'hA5});
    lat_l = t_r - t_s;
    chk(16'(lat_l - lat_e), 16'h0008);
    xfer(1'b1, 8'h20, SIZE_HALF, 4'h3, 1'b0);
    chk(16'(rq.size()), 16'h0003);
    chk(rq[1], 16'h5678);
    chk({8'h00, aq[2]}, 16'h0024);
    for (int i = 0; i < 8; i++) wd[i] = 16'hC000 + 16'(i);
    xfer(1'b0, 8'h40, SIZE_HALF, 4'h6, 1'b1);
    chk(16'(aq.size() > 0 && aq.size() < 4), 16'h0001);
    chk({mem[8'h4B], mem[8'h4A]}, {~8'h4B, ~8'h4A});
    sb_err = 1'b1;
    @(negedge ref_clk);
    sb_err = 1'b0;
    repeat (40) @(negedge ref_clk);
    chk({15'h0000, irq_pend}, 16'h0001);
    chk({15'h0000, hif.host_interrupt_n}, 16'h0000);
    chk({15'h0000, host_irq}, 16'h0001);
    irq_clr = 1'b1;
    @(negedge ref_clk);
    irq_clr = 1'b0;
    repeat (40) @(negedge ref_clk);
    chk({14'h0000, hif.host_interrupt_n, irq_pend}, 16'h0002);
    // Second run: narrow lanes, system clock not from the link
    do_reset(1'b0, 1'b0);
    chk({15'h0000, sync_mode}, 16'h0000);
    xfer(1'b1, 8'h20, SIZE_HALF, 4'h0, 1'b0);
    chk({rq[1][7:0], rq[0][7:0]}, 16'h1234);
    chk({8'h00, aq[1]}, 16'h0021);
    chk(16'(t_r - t_s), 16'(lat_l));
    xfer(1'b0, 8'h50, SIZE_WORD, 4'h0, 1'b0);
    chk({mem[8'h51], mem[8'h50]}, 16'h0100);
    chk({mem[8'h53], mem[8'h52]}, 16'h0302);
    summarize();
  end
endmodule
